// file: src/pcbd_arbiter.v
// two-tier rotating arbiter for the secondary bus masters and the bridge
`timescale 1ns/1ns
`include "pcbd_defs.vh"

module pcbd_arbiter #(
  parameter N = `PCBD_NUM_MASTERS
) (
  input wire clk,
  input wire resetn,
  input wire [N-1:0] request,
  input wire bridge_request,
  input wire [N:0] high_tier,
  input wire park_mode,
  input wire bus_idle,
  output reg [N-1:0] grant,
  output reg bridge_grant
);

  // agent index N is the bridge itself
  wire [N:0] req_all;
  wire [N:0] req_hi;
  wire [N:0] req_lo;
  reg [N:0] ptr_hi;
  reg [N:0] ptr_lo;
  reg [N:0] owner;
  reg [N:0] next_owner;
  reg [N:0] pick_hi;
  reg [N:0] pick_lo;

  assign req_all = {bridge_request, request};
  assign req_hi = req_all & high_tier;
  assign req_lo = req_all & ~high_tier;

  // ------------------------------------------------------------
  // round-robin pick within each tier, starting after the last winner
  // ------------------------------------------------------------
  always @* begin
    pick_hi = rr_pick(req_hi, ptr_hi);
    pick_lo = rr_pick(req_lo, ptr_lo);
  end

  // one-hot rotating pick: first requester above the previous winner
  function [N:0] rr_pick;
    input [N:0] req;
    input [N:0] last;
    reg [2*N+1:0] dbl;
    reg [2*N+1:0] mask;
    integer j;
    reg found;
    begin
      rr_pick = {(N+1){1'b0}};
      found = 1'b0;
      dbl = {req, req};
      mask = {(2*N+2){1'b0}};
      for (j = 0; j <= N; j = j + 1) begin
        if (last[j]) begin
          mask = {(2*N+2){1'b1}} << (j + 1);
        end
      end
      if (last == {(N+1){1'b0}}) begin
        mask = {(2*N+2){1'b1}};
      end
      for (j = 0; j <= 2 * N + 1; j = j + 1) begin
        if (!found && dbl[j] && mask[j]) begin
          found = 1'b1;
          rr_pick[j % (N + 1)] = 1'b1;
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // tier priority, then parking when nobody asks
  // ------------------------------------------------------------
  always @* begin
    if (!bus_idle) begin
      next_owner = owner; // no re-arbitration mid-transaction
    end else if (req_hi != {(N+1){1'b0}}) begin
      next_owner = pick_hi;
    end else if (req_lo != {(N+1){1'b0}}) begin
      next_owner = pick_lo;
    end else if (park_mode == `PCBD_PARK_BRIDGE) begin
      next_owner = {1'b1, {N{1'b0}}};
    end else begin
      next_owner = owner;
    end
  end

  // grant registers; rotation pointers follow the winner of each tier
  always @(posedge clk) begin
    if (!resetn) begin
      owner <= {1'b1, {N{1'b0}}};
      ptr_hi <= {(N+1){1'b0}};
      ptr_lo <= {(N+1){1'b0}};
      grant <= {N{1'b0}};
      bridge_grant <= 1'b1;
    end else begin
      owner <= next_owner;
      if (bus_idle && req_hi != {(N+1){1'b0}}) begin
        ptr_hi <= pick_hi;
      end
      if (bus_idle && req_hi == {(N+1){1'b0}} && req_lo != {(N+1){1'b0}}) begin
        ptr_lo <= pick_lo;
      end
      grant <= next_owner[N-1:0];
      bridge_grant <= next_owner[N];
    end
  end

endmodule

// file: src/pcbd_defs.vh
// constants shared by the bridge command decode front end
`ifndef PCBD_DEFS_VH
`define PCBD_DEFS_VH

// ------------------------------------------------------------
// bus command codes on the command/byte-enable lines
// ------------------------------------------------------------
`define PCBD_CMD_INT_ACK 4'h0
`define PCBD_CMD_SPECIAL 4'h1
`define PCBD_CMD_IO_RD 4'h2
`define PCBD_CMD_IO_WR 4'h3
`define PCBD_CMD_MEM_RD 4'h6
`define PCBD_CMD_MEM_WR 4'h7
`define PCBD_CMD_CFG_RD 4'ha
`define PCBD_CMD_CFG_WR 4'hb
`define PCBD_CMD_MEM_RD_MULT 4'hc
`define PCBD_CMD_DUAL_ADDR 4'hd
`define PCBD_CMD_MEM_RD_LINE 4'he
`define PCBD_CMD_MEM_WR_INV 4'hf

// ------------------------------------------------------------
// configuration address fields
// ------------------------------------------------------------
`define PCBD_CFG_TYPE_LSB 0
`define PCBD_CFG_TYPE_MSB 1
`define PCBD_CFG_TYPE0 2'h0
`define PCBD_CFG_TYPE1 2'h1
`define PCBD_FUNC_LSB 8
`define PCBD_FUNC_MSB 10
`define PCBD_DEV_LSB 11
`define PCBD_DEV_MSB 15
`define PCBD_BUS_LSB 16
`define PCBD_BUS_MSB 23
`define PCBD_FUNC_ZERO 3'h0
`define PCBD_SPC_DEV 5'h1f
`define PCBD_SPC_FUNC 3'h7

// ------------------------------------------------------------
// timing and arbiter
// ------------------------------------------------------------
`define PCBD_DEVSEL_DELAY 2'h2
`define PCBD_NUM_MASTERS 4
`define PCBD_PARK_BRIDGE 1'b0
`define PCBD_PARK_LAST 1'b1

`endif

// file: src/pcbd_top.v
// command decode, target claim and special cycle front end of the bridge
//
// Summary of operation
// - two independent 32-bit buses up to 33 MHz, each decoded separately
// - configuration header claimed only from primary configuration cycles
// - four secondary masters, each with active-low request and grant
// - arbiter rotates within two tiers set per agent by high_tier; bridge holds the grant after reset
// - idle grant parks on bridge or on last master, by setting
// - memory command codes 0110, 0111, 1100, 1110, 1111
// - io and configuration command codes 0010, 0011, 1010, 1011
// - never claim interrupt acknowledge, special cycle, dual address, reserved
// - type 1 special cycle request makes the bridge run a special cycle
// - device select asserted exactly two clocks after the address phase
// - claim decided from command and address sampled in address phase
// - memory write and invalidate forwarded as plain memory write
// - type 0 config claimed only with select active and function zero
// - special request: bus equals secondary, device 1fh, function 07h
`timescale 1ns/1ns
`include "pcbd_defs.vh"

module pcbd_top #(
  parameter N = `PCBD_NUM_MASTERS
) (
  input wire clk,
  input wire resetn,
  // primary bus address phase, already in this clock domain
  input wire p_addr_valid,
  input wire [31:0] p_ad,
  input wire [3:0] p_cbe,
  input wire primary_config_select,
  // secondary bus address phase
  input wire s_addr_valid,
  input wire [31:0] s_ad,
  input wire [3:0] s_cbe,
  // window and bus number settings from the configuration header
  input wire [7:0] secondary_bus,
  input wire [7:0] subordinate_bus,
  input wire [31:0] io_base,
  input wire [31:0] io_limit,
  input wire [31:0] mem_base,
  input wire [31:0] mem_limit,
  // data phase word of a claimed primary configuration write
  input wire p_data_valid,
  input wire [31:0] p_data,
  // arbiter settings and requests
  input wire [N:0] high_tier,
  input wire park_mode,
  input wire secondary_bus_idle,
  input wire [N-1:0] secondary_master_request_n,
  input wire bridge_secondary_request,
  // device select pins, open drain style
  output reg p_devsel_n_out,
  output reg p_devsel_oe,
  output reg s_devsel_n_out,
  output reg s_devsel_oe,
  // decode results for the forwarding engine
  output reg p_claim_cfg,
  output reg p_claim_fwd,
  output reg s_claim_fwd,
  output reg [3:0] p_fwd_cmd,
  output reg [3:0] s_fwd_cmd,
  // special cycle launch and arbiter grants on the secondary bus
  output reg spc_start,
  output reg [31:0] spc_message,
  output wire [N-1:0] secondary_master_grant_n,
  output wire bridge_secondary_grant
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SPC = 2'h2;

  // ------------------------------------------------------------
  // request pins come from the bus: two flops before use
  // ------------------------------------------------------------
  reg [N-1:0] req_meta;
  reg [N-1:0] req_sync;
  always @(posedge clk) begin
    if (!resetn) begin
      req_meta <= {N{1'b1}};
      req_sync <= {N{1'b1}};
    end else begin
      req_meta <= secondary_master_request_n;
      req_sync <= req_meta;
    end
  end

  wire [N-1:0] grant;
  pcbd_arbiter #(.N(N)) u_arb (
    .clk(clk),
    .resetn(resetn),
    .request(~req_sync),
    .bridge_request(bridge_secondary_request),
    .high_tier(high_tier),
    .park_mode(park_mode),
    .bus_idle(secondary_bus_idle),
    .grant(grant),
    .bridge_grant(bridge_secondary_grant)
  );
  assign secondary_master_grant_n = ~grant;

  // ------------------------------------------------------------
  // command classification
  // ------------------------------------------------------------
  function is_mem;
    input [3:0] c;
    begin
      is_mem = (c == `PCBD_CMD_MEM_RD) || (c == `PCBD_CMD_MEM_WR) ||
        (c == `PCBD_CMD_MEM_RD_MULT) || (c == `PCBD_CMD_MEM_RD_LINE) ||
        (c == `PCBD_CMD_MEM_WR_INV);
    end
  endfunction

  function is_io;
    input [3:0] c;
    begin
      is_io = (c == `PCBD_CMD_IO_RD) || (c == `PCBD_CMD_IO_WR);
    end
  endfunction

  function is_cfg;
    input [3:0] c;
    begin
      is_cfg = (c == `PCBD_CMD_CFG_RD) || (c == `PCBD_CMD_CFG_WR);
    end
  endfunction

  // invalidate variant goes out as plain write
  function [3:0] fwd_cmd;
    input [3:0] c;
    begin
      fwd_cmd = (c == `PCBD_CMD_MEM_WR_INV) ? `PCBD_CMD_MEM_WR : c;
    end
  endfunction

  // ------------------------------------------------------------
  // primary decode, from the address phase only
  // ------------------------------------------------------------
  wire [1:0] p_type = p_ad[`PCBD_CFG_TYPE_MSB:`PCBD_CFG_TYPE_LSB];
  wire [7:0] p_bus = p_ad[`PCBD_BUS_MSB:`PCBD_BUS_LSB];
  wire [4:0] p_dev = p_ad[`PCBD_DEV_MSB:`PCBD_DEV_LSB];
  wire [2:0] p_func = p_ad[`PCBD_FUNC_MSB:`PCBD_FUNC_LSB];
  wire p_in_io = (p_ad >= io_base) && (p_ad <= io_limit);
  wire p_in_mem = (p_ad >= mem_base) && (p_ad <= mem_limit);
  wire p_cfg0 = is_cfg(p_cbe) && (p_type == `PCBD_CFG_TYPE0) &&
    primary_config_select && (p_func == `PCBD_FUNC_ZERO);
  wire p_cfg1 = is_cfg(p_cbe) && (p_type == `PCBD_CFG_TYPE1) &&
    (p_bus >= secondary_bus) && (p_bus <= subordinate_bus);
  wire p_spc_req = (p_cbe == `PCBD_CMD_CFG_WR) && (p_type == `PCBD_CFG_TYPE1) &&
    (p_bus == secondary_bus) && (p_dev == `PCBD_SPC_DEV) &&
    (p_func == `PCBD_SPC_FUNC);
  // downstream forwarding: addresses inside the windows, type 1 configuration within the bus range
  wire p_fwd = (is_mem(p_cbe) && p_in_mem) || (is_io(p_cbe) && p_in_io) ||
    p_cfg1;
  wire p_claim = p_addr_valid && (p_cfg0 || p_fwd);

  // ------------------------------------------------------------
  // secondary decode: upstream for addresses outside the windows;
  // configuration cycles are never claimed here
  // ------------------------------------------------------------
  wire s_in_io = (s_ad >= io_base) && (s_ad <= io_limit);
  wire s_in_mem = (s_ad >= mem_base) && (s_ad <= mem_limit);
  wire s_claim = s_addr_valid && ((is_mem(s_cbe) && !s_in_mem) ||
    (is_io(s_cbe) && !s_in_io));

  // ------------------------------------------------------------
  // per-bus claim timing: device select two clocks after address
  // ------------------------------------------------------------
  reg [1:0] p_state;
  reg [1:0] s_state;
  reg [1:0] p_cnt;
  reg [1:0] s_cnt;
  reg p_spc_pending;

  // primary side state machine
  always @(posedge clk) begin
    if (!resetn) begin
      p_state <= ST_IDLE;
      p_cnt <= 2'h0;
      p_devsel_n_out <= 1'b1;
      p_devsel_oe <= 1'b0;
      p_claim_cfg <= 1'b0;
      p_claim_fwd <= 1'b0;
      p_fwd_cmd <= 4'h0;
      p_spc_pending <= 1'b0;
      spc_start <= 1'b0;
      spc_message <= 32'h0000_0000;
    end else begin
      spc_start <= 1'b0;
      case (p_state)
        ST_IDLE: begin
          p_devsel_n_out <= 1'b1;
          p_devsel_oe <= 1'b0;
          if (p_claim) begin
            p_state <= ST_WAIT;
            p_cnt <= 2'h1;
            p_claim_cfg <= p_cfg0;
            p_claim_fwd <= p_fwd;
            p_fwd_cmd <= fwd_cmd(p_cbe);
            p_spc_pending <= p_spc_req;
          end
        end
        ST_WAIT: begin
          p_cnt <= p_cnt + 2'h1;
          if (p_cnt == `PCBD_DEVSEL_DELAY - 2'h1) begin
            p_devsel_n_out <= 1'b0;
            p_devsel_oe <= 1'b1;
            p_state <= p_spc_pending ? ST_SPC : ST_IDLE;
          end
        end
        ST_SPC: begin
          // device select stands one cycle, even while the message is awaited
          p_devsel_n_out <= 1'b1;
          p_devsel_oe <= 1'b0;
          // message is the data word of the configuration write
          if (p_data_valid) begin
            spc_message <= p_data;
            spc_start <= 1'b1;
            p_spc_pending <= 1'b0;
            p_state <= ST_IDLE;
          end
        end
        default: begin
          p_state <= ST_IDLE;
        end
      endcase
    end
  end

  // secondary side runs its own decode, independent of the primary
  always @(posedge clk) begin
    if (!resetn) begin
      s_state <= ST_IDLE;
      s_cnt <= 2'h0;
      s_devsel_n_out <= 1'b1;
      s_devsel_oe <= 1'b0;
      s_claim_fwd <= 1'b0;
      s_fwd_cmd <= 4'h0;
    end else begin
      case (s_state)
        ST_IDLE: begin
          s_devsel_n_out <= 1'b1;
          s_devsel_oe <= 1'b0;
          if (s_claim) begin
            s_state <= ST_WAIT;
            s_cnt <= 2'h1;
            s_claim_fwd <= 1'b1;
            s_fwd_cmd <= fwd_cmd(s_cbe);
          end
        end
        ST_WAIT: begin
          s_cnt <= s_cnt + 2'h1;
          if (s_cnt == `PCBD_DEVSEL_DELAY - 2'h1) begin
            s_devsel_n_out <= 1'b0;
            s_devsel_oe <= 1'b1;
            s_state <= ST_IDLE;
          end
        end
        default: begin
          s_state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// file: testbench/pcbd_host_model.sv
// initiator model that issues address phases and data words on one bus
`timescale 1ns/1ns
module pcbd_host_model (
  input wire clk,
  output reg addr_valid,
  output reg [31:0] ad,
  output reg [3:0] cbe,
  output reg config_select,
  output reg data_valid,
  output reg [31:0] data
);
  initial begin
    addr_valid = 1'b0;
    ad = 32'h0;
    cbe = 4'h0;
    config_select = 1'b0;
    data_valid = 1'b0;
    data = 32'h0;
  end
  // one address phase; after release ad and cbe show the inverse, never the old value, and config_select drops to 0
  task addr_phase(input logic [3:0] c, input logic [31:0] a, input logic sel);
    begin
      @(posedge clk);
      #1;
      addr_valid = 1'b1;
      ad = a;
      cbe = c;
      config_select = sel;
      @(posedge clk);
      #1;
      addr_valid = 1'b0;
      ad = ~a;
      cbe = ~c;
      config_select = 1'b0;
    end
  endtask
  // one data word of a claimed configuration write
  task data_word(input logic [31:0] d);
    begin
      @(posedge clk);
      #1;
      data_valid = 1'b1;
      data = d;
      @(posedge clk);
      #1;
      data_valid = 1'b0;
      data = ~d;
    end
  endtask
endmodule

// file: testbench/pcbd_top_chk.sv
// assertion checker for the bridge command decode front end
`timescale 1ns/1ns
module pcbd_top_chk (
  input wire clk,
  input wire resetn,
  input wire p_addr_valid,
  input wire [31:0] p_ad,
  input wire [3:0] p_cbe,
  input wire primary_config_select,
  input wire s_addr_valid,
  input wire [3:0] s_cbe,
  input wire p_data_valid,
  input wire [31:0] p_data,
  input wire p_devsel_n_out,
  input wire p_devsel_oe,
  input wire s_devsel_oe,
  input wire [3:0] p_fwd_cmd,
  input wire spc_start,
  input wire [31:0] spc_message,
  input wire [3:0] secondary_master_grant_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // codes 0,1,4,5,8,9 and d are never claimed
  wire p_bad = (p_cbe[3:1] == 3'h0) || (p_cbe[3:1] == 3'h2) || (p_cbe[3:1] == 3'h4)
               || (p_cbe == 4'hd);
  // type 0 configuration that is not addressed to function zero of this bridge
  wire p_t0_miss = (p_cbe[3:1] == 3'h5) && (p_ad[1:0] == 2'h0)
                   && (!primary_config_select || (p_ad[10:8] != 3'h0));

  a_devsel_two_late: assert property (p_devsel_oe |-> $past(p_addr_valid, 2))
    else $error("primary device select without address phase two cycles before");
  a_devsel_one_cyc: assert property (p_devsel_oe |=> !p_devsel_oe)
    else $error("primary device select held beyond one cycle");
  a_devsel_low: assert property (p_devsel_oe |-> !p_devsel_n_out)
    else $error("primary device select driven high");
  a_refused_cmd: assert property (p_addr_valid && p_bad |-> ##2 !p_devsel_oe)
    else $error("refused command was claimed");
  a_sec_cfg_none: assert property (s_addr_valid && (s_cbe[3:1] == 3'h5) |-> ##2 !s_devsel_oe)
    else $error("configuration cycle claimed on secondary side");
  a_type0_miss: assert property (p_addr_valid && p_t0_miss |-> ##2 !p_devsel_oe)
    else $error("type 0 configuration claimed without select or function zero");
  a_mwi_as_wr: assert property ((p_addr_valid && (p_cbe == 4'hf)) ##2 p_devsel_oe
    |-> p_fwd_cmd == 4'h7)
    else $error("write and invalidate not reissued as plain write");
  a_spc_message: assert property (spc_start |-> $past(p_data_valid, 1)
    && (spc_message == $past(p_data, 1)))
    else $error("special cycle message does not follow the data word");
  a_spc_pulse: assert property (spc_start |=> !spc_start)
    else $error("special cycle start longer than one cycle");
  a_grant_single: assert property ($onehot0(~secondary_master_grant_n))
    else $error("more than one secondary grant active");

  c_claim: cover property (p_devsel_oe);
  c_spc: cover property (spc_start);
  c_mwi: cover property (p_addr_valid && (p_cbe == 4'hf));
endmodule

// file: testbench/pcbd_top_tb_top.sv
// self-checking testbench of the bridge command decode front end
`timescale 1ns/1ns
module pcbd_top_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] mem_base = 32'h1000_0000;
  logic [31:0] mem_limit = 32'h1fff_ffff;
  logic [4:0] high_tier = 5'h10;
  logic park_mode = 1'b0;
  logic [3:0] req_n = 4'hf;
  logic br_req = 1'b0;
  logic s_idle = 1'b1;
  wire p_av, p_sel, p_dv, s_av, p_oe, p_n, s_oe, s_n, cfg, pf, sf, spc, bg;
  wire [31:0] p_ad, p_data, s_ad, msg;
  wire [3:0] p_cbe, s_cbe, pcmd, scmd, gnt_n;
  int err_count = 0;
  int n_tests = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  pcbd_host_model pm (.clk(clk), .addr_valid(p_av), .ad(p_ad), .cbe(p_cbe),
    .config_select(p_sel), .data_valid(p_dv), .data(p_data));
  pcbd_host_model sm (.clk(clk), .addr_valid(s_av), .ad(s_ad), .cbe(s_cbe),
    .config_select(), .data_valid(), .data());
  pcbd_top dut (.clk(clk), .resetn(resetn), .p_addr_valid(p_av), .p_ad(p_ad), .p_cbe(p_cbe),
    .primary_config_select(p_sel), .s_addr_valid(s_av), .s_ad(s_ad), .s_cbe(s_cbe),
    .secondary_bus(8'h02), .subordinate_bus(8'h05), .io_base(32'h0000_1000),
    .io_limit(32'h0000_1fff), .mem_base(mem_base), .mem_limit(mem_limit),
    .p_data_valid(p_dv), .p_data(p_data), .high_tier(high_tier), .park_mode(park_mode),
    .secondary_bus_idle(s_idle), .secondary_master_request_n(req_n),
    .bridge_secondary_request(br_req), .p_devsel_n_out(p_n), .p_devsel_oe(p_oe),
    .s_devsel_n_out(s_n), .s_devsel_oe(s_oe), .p_claim_cfg(cfg), .p_claim_fwd(pf),
    .s_claim_fwd(sf), .p_fwd_cmd(pcmd), .s_fwd_cmd(scmd), .spc_start(spc),
    .spc_message(msg), .secondary_master_grant_n(gnt_n), .bridge_secondary_grant(bg));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      n_tests++;
      if (seen !== exp) begin
        err_count++;
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  // device select on bus b must appear in cycle 2 only, and only when claimed
  task see_devsel(input logic b, input logic cl);
    begin
      chk("devsel_early", b ? s_oe : p_oe, 0);
      @(posedge clk);
      #1;
      chk("devsel_oe", b ? s_oe : p_oe, cl);
      chk("devsel_n", b ? s_n : p_n, !cl);
      @(posedge clk);
      #1;
      chk("devsel_off", b ? s_oe : p_oe, 0);
    end
  endtask
  task do_reset;
    begin
      @(posedge clk);
      #1;
      resetn = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk("rst_oe", {p_oe, s_oe, spc}, 0);
      chk("rst_grant", {bg, gnt_n}, 5'h1f);
      resetn = 1'b1;
    end
  endtask
  task wait_gnt(input logic [4:0] e);
    int k;
    begin
      k = 0;
      while ({bg, gnt_n} !== e && k < 12) begin
        @(posedge clk);
        #1;
        k++;
      end
      chk("grant", {bg, gnt_n}, e);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // every command code on the primary bus, each aimed at a claimable place
  task t_cmds;
    logic [3:0] c;
    logic [31:0] a;
    logic cl;
    begin
      for (int i = 0; i < 16; i++) begin
        c = i[3:0];
        a = (c[3:1] == 3'h1) ? 32'h0000_1040 : (c[3:1] == 3'h5) ? 32'h4 : 32'h1000_0040;
        cl = 16'hdccc >> i;
        pm.addr_phase(c, a, 1'b1);
        see_devsel(1'b0, cl);
        if (cl && c[3:1] != 3'h5) chk("p_fwd_cmd", pcmd, c == 4'hf ? 4'h7 : c);
        if (cl && c[3:1] == 3'h5) chk("p_claim_cfg", cfg, 1);
        if (cl) chk("p_claim_fwd", pf, c[3:1] != 3'h5);
      end
    end
  endtask
  task t_type0;
    begin
      pm.addr_phase(4'ha, 32'h0000_0104, 1'b1);
      see_devsel(1'b0, 1'b0);
      pm.addr_phase(4'hb, 32'h0000_0004, 1'b0);
      see_devsel(1'b0, 1'b0);
    end
  endtask
  // address outside the window, then the window moved over it
  task t_window;
    begin
      pm.addr_phase(4'h6, 32'h3000_0000, 1'b0);
      see_devsel(1'b0, 1'b0);
      mem_base = 32'h3000_0000;
      mem_limit = 32'h3fff_ffff;
      pm.addr_phase(4'h6, 32'h3000_0000, 1'b0);
      see_devsel(1'b0, 1'b1);
      mem_base = 32'h1000_0000;
      mem_limit = 32'h1fff_ffff;
    end
  endtask
  task t_second;
    begin
      sm.addr_phase(4'hf, 32'h4000_0000, 1'b0);
      see_devsel(1'b1, 1'b1);
      chk("s_fwd_cmd", scmd, 4'h7);
      chk("s_claim_fwd", sf, 1);
      sm.addr_phase(4'ha, 32'h0000_0004, 1'b0);
      see_devsel(1'b1, 1'b0);
      sm.addr_phase(4'h7, 32'h1000_0040, 1'b0);
      see_devsel(1'b1, 1'b0);
    end
  endtask
  task t_special;
    int k;
    begin
      pm.addr_phase(4'hb, {8'h00, 8'h02, 5'h1f, 3'h7, 8'h01}, 1'b0);
      see_devsel(1'b0, 1'b1);
      pm.data_word(32'hc0de_5a5a);
      k = 0;
      while (spc !== 1'b1 && k < 10) begin
        @(posedge clk);
        #1;
        k++;
      end
      chk("spc_start", spc, 1);
      chk("spc_message", msg, 32'hc0de_5a5a);
    end
  endtask
  // master 3 in the high tier beats master 1, then parking and the bridge
  task t_arb;
    begin
      high_tier = 5'h18;
      park_mode = 1'b1;
      req_n = 4'h5;
      wait_gnt(5'h07);
      req_n = 4'hd;
      wait_gnt(5'h0d);
      req_n = 4'hf;
      repeat (6) @(posedge clk);
      #1;
      chk("park_last", {bg, gnt_n}, 5'h0d);
      // a busy bus freezes the grant even for a high-tier request
      s_idle = 1'b0;
      br_req = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk("grant_busy", {bg, gnt_n}, 5'h0d);
      s_idle = 1'b1;
      wait_gnt(5'h1f);
      br_req = 1'b0;
      park_mode = 1'b0;
      high_tier = 5'h10;
    end
  endtask

  initial begin
    do_reset;
    t_cmds;
    t_type0;
    t_window;
    t_second;
    t_special;
    t_arb;
    do_reset;
    t_special;
    results;
  end
endmodule

bind pcbd_top pcbd_top_chk u_chk (.clk(clk), .resetn(resetn), .p_addr_valid(p_addr_valid),
  .p_ad(p_ad), .p_cbe(p_cbe), .primary_config_select(primary_config_select),
  .s_addr_valid(s_addr_valid), .s_cbe(s_cbe), .p_data_valid(p_data_valid), .p_data(p_data),
  .p_devsel_n_out(p_devsel_n_out), .p_devsel_oe(p_devsel_oe), .s_devsel_oe(s_devsel_oe),
  .p_fwd_cmd(p_fwd_cmd), .spc_start(spc_start), .spc_message(spc_message),
  .secondary_master_grant_n(secondary_master_grant_n));
